/* logic/twimr_pkg.sv */
// constants and types shared by the two-wire master transmit block
`default_nettype none
package twimr_pkg;
  localparam int CLK_PERIOD_NS   = 25;
  localparam int START_DELAY_NS  = 1615;
  localparam int START_DELAY_CYC = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_RATE_KBPS   = 100;
  localparam int BIT_PERIOD_NS   = 1000000 / BIT_RATE_KBPS;
  localparam int QUARTER_CYC     = BIT_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int CNT_W           = 13;
  localparam int LIST_W          = 2;
  localparam int SLV_W           = 7;
  localparam int EVT_W           = 3;
  localparam logic [11:0] OFS_TASK_TX    = 12'h000;
  localparam logic [11:0] OFS_TASK_RX    = 12'h004;
  localparam logic [11:0] OFS_EVT_STATUS = 12'h104;
  localparam logic [11:0] OFS_BUSY       = 12'h108;
  localparam logic [11:0] OFS_IRQ_EN     = 12'h300;
  localparam logic [11:0] OFS_IRQ_CLR    = 12'h308;
  localparam logic [11:0] OFS_ERR_SRC    = 12'h4c4;
  localparam logic [11:0] OFS_BUFFER_BYTE_LIMIT     = 12'h548;
  localparam logic [11:0] OFS_BYTES_MOVED_COUNT     = 12'h54c;
  localparam logic [11:0] OFS_LIST       = 12'h550;
  localparam logic [11:0] OFS_ADDRESS    = 12'h588;
  localparam int EVT_STOPPED = 0;
  localparam int EVT_ERROR   = 1;
  localparam int EVT_STARTED = 2;
  localparam int ERR_ANACK   = 1;
  localparam int ERR_DATA_REFUSED_FLAG   = 2;
  localparam logic [LIST_W-1:0] LIST_OFF   = 2'h0;
  localparam logic [LIST_W-1:0] LIST_ARRAY = 2'h1;
  localparam logic [CNT_W-1:0]  RST_CNT    = 13'h0000;
  localparam logic [LIST_W-1:0] RST_LIST   = 2'h0;
  localparam logic [SLV_W-1:0]  RST_SLV    = 7'h00;
  localparam logic [EVT_W-1:0]  RST_EVT    = 3'h0;
  typedef enum logic [1:0] {
    twimr_op_start,
    twimr_op_byte,
    twimr_op_stop
  } twimr_op_t;
endpackage
`default_nettype wire

/* logic/twimr_bit_if.sv */
// handshake between the transaction sequencer and the bit engine
`default_nettype none
interface twimr_bit_if;
  twimr_pkg::twimr_op_t op;
  logic                 go;
  logic [7:0]           tx_byte;
  logic                 done;
  logic                 refused;
  modport ctrl (output op, output go, output tx_byte, input done, input refused);
  modport eng  (input op, input go, input tx_byte, output done, output refused);
endinterface
`default_nettype wire

/* logic/twimr_bit_engine.sv */
// bit engine: start, byte with acknowledge, stop, with clock stretching
`default_nettype none
module twimr_bit_engine #(
  parameter int QUARTER = twimr_pkg::QUARTER_CYC
) (
  input  wire logic    pclk,
  input  wire logic    presetn,
  input  wire logic    scl_sync,
  input  wire logic    sda_sync,
  output var  logic    scl_oe,
  output var  logic    sda_oe,
  twimr_bit_if.eng     bus
);
  typedef enum {twimr_e_idle, twimr_e_run} twimr_estate_t;
  twimr_estate_t        state;
  twimr_pkg::twimr_op_t op_q;
  logic [15:0]          qcnt;
  logic [1:0]           phase;
  logic [3:0]           bitn;
  logic [8:0]           shreg;
  logic                 tick;
  logic                 stall;

  initial begin
    if (QUARTER < 2 || QUARTER > 65535) $error("quarter period out of range");
  end

  // slave holding scl low stretches the high phase
  assign stall = (phase == 2'd2) && !scl_sync && (op_q != twimr_pkg::twimr_op_start);
  assign tick  = (qcnt == 16'(QUARTER - 1)) && !stall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= twimr_e_idle;
      op_q     <= twimr_pkg::twimr_op_start;
      qcnt     <= 16'h0000;
      phase    <= 2'h0;
      bitn     <= 4'h0;
      shreg    <= 9'h000;
      scl_oe   <= 1'b0;
      sda_oe   <= 1'b0;
      bus.done <= 1'b0;
      bus.refused <= 1'b0;
    end else begin
      bus.done <= 1'b0;
      case (state)
        twimr_e_idle: begin
          if (bus.go) begin
            state <= twimr_e_run;
            op_q  <= bus.op;
            qcnt  <= (bus.op == twimr_pkg::twimr_op_start) ? 16'(QUARTER - 1) : 16'h0000;
            phase <= 2'h0;
            bitn  <= 4'h0;
            shreg <= {bus.tx_byte, 1'b1};
          end
        end
        default: begin
          if (!stall) begin
            qcnt <= tick ? 16'h0000 : qcnt + 16'h0001;
          end
          if (tick) begin
            phase <= phase + 2'h1;
            case (op_q)
              twimr_pkg::twimr_op_start: begin
                if (phase == 2'h0) begin
                  sda_oe <= 1'b1;
                end else begin
                  scl_oe   <= 1'b1;
                  bus.done <= 1'b1;
                  state    <= twimr_e_idle;
                end
              end
              twimr_pkg::twimr_op_byte: begin
                if (phase == 2'h0) begin
                  sda_oe <= ~shreg[8];
                end else if (phase == 2'h1) begin
                  scl_oe <= 1'b0;
                end else if (phase == 2'h2) begin
                  if (bitn == 4'h8) bus.refused <= sda_sync;
                end else begin
                  scl_oe <= 1'b1;
                  shreg  <= {shreg[7:0], 1'b1};
                  bitn   <= bitn + 4'h1;
                  if (bitn == 4'h8) begin
                    bus.done <= 1'b1;
                    state    <= twimr_e_idle;
                  end
                end
              end
              default: begin
                if (phase == 2'h0) begin
                  sda_oe <= 1'b1;
                end else if (phase == 2'h1) begin
                  scl_oe <= 1'b0;
                end else if (phase == 2'h2) begin
                  sda_oe <= 1'b0;
                end else begin
                  bus.done <= 1'b1;
                  state    <= twimr_e_idle;
                end
              end
            endcase
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* logic/twimr_top.sv */
// two-wire master transmit sequencer with apb registers
// Function
// - software sets how many bytes one transmission may fetch, zero to 0x1fff
// - read-only count of bytes sent last time, refused byte included
// - list setting: 0 turns list off, 1 selects array list stepping
// - programmed slave address goes into the address phase of every transfer
// - bus activity begins about 1.615 us after a start command
// - refused data byte sets a sticky flag, cleared by writing one
`default_nettype none
module twimr_top #(
  parameter int RAM_AW = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  output var  logic              irq,
  output var  logic              ram_rd_req,
  output var  logic [RAM_AW-1:0] ram_rd_addr,
  input  wire logic [7:0]        ram_rd_data,
  input  wire logic              ram_rd_valid,
  input  wire logic              scl_in,
  output wire logic              scl_out,
  output wire logic              scl_oe,
  input  wire logic              sda_in,
  output wire logic              sda_out,
  output wire logic              sda_oe
);
  localparam int CW = twimr_pkg::CNT_W;
  localparam int EW = twimr_pkg::EVT_W;

  typedef enum {
    twimr_idle,
    twimr_delay,
    twimr_start,
    twimr_addr,
    twimr_fetch,
    twimr_data,
    twimr_stop
  } twimr_state_t;

  initial begin
    if (RAM_AW < CW) $error("ram address narrower than the byte counter");
  end

  // registers
  logic [CW-1:0]                 buffer_byte_limit;
  logic [CW-1:0]                 bytes_moved_count;
  logic [twimr_pkg::LIST_W-1:0]  tx_list_type;
  logic [twimr_pkg::SLV_W-1:0]   target_slave_address;
  logic [EW-1:0]                 evt_status;
  logic [EW-1:0]                 irq_enable;
  logic                          addr_refused_flag;
  logic                          data_refused_flag;

  // sequencer state
  twimr_state_t                  state;
  logic [15:0]                   delay_cnt;
  logic                          dir_rx;
  logic                          issued;
  logic [CW-1:0]                 limit_q;
  logic [CW-1:0]                 sent_cnt;
  logic [RAM_AW-1:0]             list_base;
  logic [7:0]                    data_q;
  logic                          set_anack;
  logic                          set_data_refused_flag;
  logic                          set_stopped;
  logic                          set_started;

  // apb strobes
  logic                          acc;
  logic                          wr;
  logic                          rd;
  logic                          cmd_tx;
  logic                          cmd_rx;
  logic [EW-1:0]                 clr_evt;
  logic [31:0]                   next_prdata;

  // pin synchronisers
  logic                          scl_s1;
  logic                          scl_s2;
  logic                          sda_s1;
  logic                          sda_s2;

  twimr_bit_if                   bit_bus ();

  // open drain: the pins are only ever pulled low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == twimr_pkg::OFS_TASK_TX)    || (a == twimr_pkg::OFS_TASK_RX)  ||
             (a == twimr_pkg::OFS_EVT_STATUS) || (a == twimr_pkg::OFS_BUSY)     ||
             (a == twimr_pkg::OFS_IRQ_EN)     || (a == twimr_pkg::OFS_IRQ_CLR)  ||
             (a == twimr_pkg::OFS_ERR_SRC)    || (a == twimr_pkg::OFS_BUFFER_BYTE_LIMIT)   ||
             (a == twimr_pkg::OFS_BYTES_MOVED_COUNT)     || (a == twimr_pkg::OFS_LIST)     ||
             (a == twimr_pkg::OFS_ADDRESS);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
    end
  end

  twimr_bit_engine #(
    .QUARTER (twimr_pkg::QUARTER_CYC)
  ) u_engine (
    .pclk     (pclk),
    .presetn  (presetn),
    .scl_sync (scl_s2),
    .sda_sync (sda_s2),
    .scl_oe   (scl_oe),
    .sda_oe   (sda_oe),
    .bus      (bit_bus.eng)
  );

  // apb: one wait state, then answer
  assign acc     = psel && penable && pready;
  assign wr      = acc && pwrite;
  assign rd      = acc && !pwrite;
  assign cmd_tx  = wr && (paddr == twimr_pkg::OFS_TASK_TX) && pwdata[0];
  assign cmd_rx  = wr && (paddr == twimr_pkg::OFS_TASK_RX) && pwdata[0];
  assign clr_evt = (wr && (paddr == twimr_pkg::OFS_IRQ_CLR)) ? pwdata[EW-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped(paddr);
      prdata  <= (psel && penable && !pready && !pwrite) ? next_prdata : 32'h00000000;
    end
  end

  always_comb begin
    next_prdata = 32'h00000000;
    if (paddr == twimr_pkg::OFS_EVT_STATUS) begin
      next_prdata[EW-1:0] = evt_status;
    end else if (paddr == twimr_pkg::OFS_BUSY) begin
      next_prdata[0] = (state != twimr_idle);
    end else if (paddr == twimr_pkg::OFS_IRQ_EN) begin
      next_prdata[EW-1:0] = irq_enable;
    end else if (paddr == twimr_pkg::OFS_ERR_SRC) begin
      next_prdata[twimr_pkg::ERR_ANACK] = addr_refused_flag;
      next_prdata[twimr_pkg::ERR_DATA_REFUSED_FLAG] = data_refused_flag;
    end else if (paddr == twimr_pkg::OFS_BUFFER_BYTE_LIMIT) begin
      next_prdata[CW-1:0] = buffer_byte_limit;
    end else if (paddr == twimr_pkg::OFS_BYTES_MOVED_COUNT) begin
      next_prdata[CW-1:0] = bytes_moved_count;
    end else if (paddr == twimr_pkg::OFS_LIST) begin
      next_prdata[twimr_pkg::LIST_W-1:0] = tx_list_type;
    end else if (paddr == twimr_pkg::OFS_ADDRESS) begin
      next_prdata[twimr_pkg::SLV_W-1:0] = target_slave_address;
    end
  end

  // software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_byte_limit    <= twimr_pkg::RST_CNT;
      tx_list_type         <= twimr_pkg::RST_LIST;
      target_slave_address <= twimr_pkg::RST_SLV;
      irq_enable           <= twimr_pkg::RST_EVT;
    end else if (wr) begin
      if (paddr == twimr_pkg::OFS_BUFFER_BYTE_LIMIT) begin
        buffer_byte_limit <= pwdata[CW-1:0];
      end else if (paddr == twimr_pkg::OFS_LIST) begin
        tx_list_type <= pwdata[twimr_pkg::LIST_W-1:0];
      end else if (paddr == twimr_pkg::OFS_ADDRESS) begin
        target_slave_address <= pwdata[twimr_pkg::SLV_W-1:0];
      end else if (paddr == twimr_pkg::OFS_IRQ_EN) begin
        irq_enable <= pwdata[EW-1:0];
      end
    end
  end

  // refusal flags: a new refusal wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_refused_flag <= 1'b0;
      data_refused_flag <= 1'b0;
    end else begin
      if (set_anack) begin
        addr_refused_flag <= 1'b1;
      end else if (wr && (paddr == twimr_pkg::OFS_ERR_SRC) && pwdata[twimr_pkg::ERR_ANACK]) begin
        addr_refused_flag <= 1'b0;
      end
      if (set_data_refused_flag) begin
        data_refused_flag <= 1'b1;
      end else if (wr && (paddr == twimr_pkg::OFS_ERR_SRC) && pwdata[twimr_pkg::ERR_DATA_REFUSED_FLAG]) begin
        data_refused_flag <= 1'b0;
      end
    end
  end

  // sticky events, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status <= twimr_pkg::RST_EVT;
    end else begin
      evt_status <= (evt_status & ~clr_evt) |
                    (EW'(set_stopped) << twimr_pkg::EVT_STOPPED) |
                    (EW'(set_anack || set_data_refused_flag) << twimr_pkg::EVT_ERROR) |
                    (EW'(set_started) << twimr_pkg::EVT_STARTED);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status & irq_enable);
    end
  end

  // transaction sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state             <= twimr_idle;
      delay_cnt         <= 16'h0000;
      dir_rx            <= 1'b0;
      issued            <= 1'b0;
      limit_q           <= twimr_pkg::RST_CNT;
      sent_cnt          <= twimr_pkg::RST_CNT;
      bytes_moved_count <= twimr_pkg::RST_CNT;
      list_base         <= '0;
      data_q            <= 8'h00;
      ram_rd_req        <= 1'b0;
      ram_rd_addr       <= '0;
      bit_bus.go        <= 1'b0;
      bit_bus.op        <= twimr_pkg::twimr_op_start;
      bit_bus.tx_byte   <= 8'h00;
      set_anack         <= 1'b0;
      set_data_refused_flag         <= 1'b0;
      set_stopped       <= 1'b0;
      set_started       <= 1'b0;
    end else begin
      bit_bus.go  <= 1'b0;
      set_anack   <= 1'b0;
      set_data_refused_flag   <= 1'b0;
      set_stopped <= 1'b0;
      set_started <= 1'b0;
      case (state)
        twimr_idle: begin
          if (cmd_tx || cmd_rx) begin
            state     <= twimr_delay;
            dir_rx    <= cmd_rx && !cmd_tx;
            delay_cnt <= 16'h0000;
            limit_q   <= buffer_byte_limit;
            sent_cnt  <= twimr_pkg::RST_CNT;
            if (tx_list_type == twimr_pkg::LIST_OFF) begin
              list_base <= '0;
            end
          end
        end
        twimr_delay: begin
          delay_cnt <= delay_cnt + 16'h0001;
          if (delay_cnt == 16'(twimr_pkg::START_DELAY_CYC - 1)) begin
            state       <= twimr_start;
            set_started <= 1'b1;
          end
        end
        twimr_start: begin
          if (!issued) begin
            bit_bus.op <= twimr_pkg::twimr_op_start;
            bit_bus.go <= 1'b1;
            issued     <= 1'b1;
          end else if (bit_bus.done) begin
            issued <= 1'b0;
            state  <= twimr_addr;
          end
        end
        twimr_addr: begin
          if (!issued) begin
            bit_bus.op      <= twimr_pkg::twimr_op_byte;
            bit_bus.tx_byte <= {target_slave_address, dir_rx};
            bit_bus.go      <= 1'b1;
            issued          <= 1'b1;
          end else if (bit_bus.done) begin
            issued <= 1'b0;
            if (bit_bus.refused) begin
              set_anack <= 1'b1;
              state     <= twimr_stop;
            end else if (dir_rx || (limit_q == twimr_pkg::RST_CNT)) begin
              state <= twimr_stop;
            end else begin
              state <= twimr_fetch;
            end
          end
        end
        twimr_fetch: begin
          if (!ram_rd_req) begin
            ram_rd_req  <= 1'b1;
            ram_rd_addr <= list_base + RAM_AW'(sent_cnt);
          end else if (ram_rd_valid) begin
            ram_rd_req <= 1'b0;
            data_q     <= ram_rd_data;
            state      <= twimr_data;
          end
        end
        twimr_data: begin
          if (!issued) begin
            bit_bus.op      <= twimr_pkg::twimr_op_byte;
            bit_bus.tx_byte <= data_q;
            bit_bus.go      <= 1'b1;
            issued          <= 1'b1;
          end else if (bit_bus.done) begin
            issued   <= 1'b0;
            sent_cnt <= sent_cnt + 13'h0001;
            if (bit_bus.refused) begin
              set_data_refused_flag <= 1'b1;
              state     <= twimr_stop;
            end else if (sent_cnt + 13'h0001 >= limit_q) begin
              state <= twimr_stop;
            end else begin
              state <= twimr_fetch;
            end
          end
        end
        default: begin
          if (!issued) begin
            bit_bus.op <= twimr_pkg::twimr_op_stop;
            bit_bus.go <= 1'b1;
            issued     <= 1'b1;
          end else if (bit_bus.done) begin
            issued            <= 1'b0;
            state             <= twimr_idle;
            set_stopped       <= 1'b1;
            bytes_moved_count <= sent_cnt;
            if (tx_list_type == twimr_pkg::LIST_ARRAY && !dir_rx) begin
              list_base <= list_base + RAM_AW'(limit_q);
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* tb/twimr_monitor.sv */
// checker on register reads and line enables
`default_nettype none
module twimr_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        rd;
  logic        wr;
  logic        go;
  logic        scl_q;
  logic        sda_q;
  logic        amt_ok;
  logic        seen;
  logic [7:0]  quiet;
  logic [31:0] amt_last;
  int          cnt;
  assign rd = psel & penable & pready & ~pwrite;
  assign wr = psel & penable & pready & pwrite;
  assign go = wr & pwdata[0] & (paddr==twimr_pkg::OFS_TASK_TX || paddr==twimr_pkg::OFS_TASK_RX);
  // cycles since a start command was accepted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 0;
    else if (go) cnt <= 1;
    else if (cnt != 0 && cnt < 100) cnt <= cnt + 1;
  end
  // cycles since either line enable last moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet <= 8'h00;
      scl_q <= 1'b0;
      sda_q <= 1'b0;
    end else begin
      scl_q <= scl_oe;
      sda_q <= sda_oe;
      if (scl_oe != scl_q || sda_oe != sda_q) quiet <= 8'h00;
      else if (quiet != 8'hff) quiet <= quiet + 8'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) amt_ok <= 1'b0;
    else if (quiet != 8'hff) amt_ok <= 1'b0;
    else if (rd && paddr == twimr_pkg::OFS_BYTES_MOVED_COUNT) amt_ok <= 1'b1;
  end
  always_ff @(posedge pclk) begin
    if (rd && paddr == twimr_pkg::OFS_BYTES_MOVED_COUNT) amt_last <= prdata;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen <= 1'b0;
    else if (wr && paddr == twimr_pkg::OFS_ERR_SRC && pwdata[2]) seen <= 1'b0;
    else if (rd && paddr == twimr_pkg::OFS_ERR_SRC && prdata[2]) seen <= 1'b1;
  end
  property p_limit_w; rd && paddr == twimr_pkg::OFS_BUFFER_BYTE_LIMIT |-> prdata[31:13] == 19'h0; endproperty
  a_limit_w: assert property (p_limit_w) else $error("limit wider than 13 bits");
  property p_amt_w; rd && paddr == twimr_pkg::OFS_BYTES_MOVED_COUNT |-> prdata[31:13] == 19'h0; endproperty
  a_amt_w: assert property (p_amt_w) else $error("count wider than 13 bits");
  property p_list_w; rd && paddr == twimr_pkg::OFS_LIST |-> prdata[31:2] == 30'h0; endproperty
  a_list_w: assert property (p_list_w) else $error("list field too wide");
  property p_addr_w; rd && paddr == twimr_pkg::OFS_ADDRESS |-> prdata[31:7] == 25'h0; endproperty
  a_addr_w: assert property (p_addr_w) else $error("slave address too wide");
  property p_start_quiet; cnt >= 1 && cnt <= 60 |-> !scl_oe && !sda_oe; endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("bus moved too early");
  property p_start_soon; go |-> ##[60:80] sda_oe; endproperty
  a_start_soon: assert property (p_start_soon) else $error("start condition late");
  property p_err_sticky; rd && paddr == twimr_pkg::OFS_ERR_SRC && seen |-> prdata[2]; endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("refusal flag lost");
  property p_amt_hold;
    rd && paddr == twimr_pkg::OFS_BYTES_MOVED_COUNT && amt_ok && quiet == 8'hff |-> prdata == amt_last;
  endproperty
  a_amt_hold: assert property (p_amt_hold) else $error("count moved while idle");
  c_go: cover property (go);
  c_amt: cover property (rd && paddr == twimr_pkg::OFS_BYTES_MOVED_COUNT && amt_ok);
  c_irq: cover property ($rose(irq));
endmodule
bind twimr_top twimr_monitor mon_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .scl_oe(scl_oe), .sda_oe(sda_oe), .irq(irq)
);
`default_nettype wire

/* tb/twimr_slave_model.sv */
// two-wire slave model: address match, acknowledge, scripted refusal
`default_nettype none
module twimr_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [6:0] own_addr,
  input  wire logic [7:0] nack_at,
  output var  logic       sda_pull,
  output var  logic       got_tog,
  output var  logic [7:0] got_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;
  int         nbit = -1;
  int         nbyte = 0;
  initial begin
    sda_pull = 1'b0;
    got_tog = 1'b0;
    got_byte = 8'h00;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    nbit = 0;
    nbyte = 0;
  end
  always @(posedge sda) if (scl === 1'b1) nbit = -1;
  always @(posedge scl) if (nbit >= 0 && nbit < 8) begin
    sh = {sh[6:0], sda};
    nbit++;
  end
  always @(negedge scl) begin
    if (nbit == 9) begin
      sda_pull = 1'b0;
      nbit = 0;
    end else if (nbit == 8) begin
      sda_pull = (nbyte == 0) ? (sh[7:1] == own_addr) : (nbyte != int'(nack_at));
      got_byte = sh;
      got_tog = ~got_tog;
      nbyte++;
      nbit = 9;
    end
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// bench with ram and slave models
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, ram_rd_req, scl_oe, sda_oe, sda_pull, got_tog, se;
  logic [15:0] ram_rd_addr;
  logic [7:0]  ram_rd_data = 8'h00;
  logic        ram_rd_valid = 1'b0;
  logic [7:0]  got_byte, rb;
  logic [7:0]  nack_at = 8'h00;
  logic [6:0]  slv = 7'h00;
  logic [31:0] rv;
  logic [7:0]  exp_q[$];
  logic [7:0]  got_q[$];
  int          adr_q[$];
  int          err_total = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          base = 0;
  logic [11:0] ofs[4] = '{twimr_pkg::OFS_BUFFER_BYTE_LIMIT, twimr_pkg::OFS_BYTES_MOVED_COUNT,
                          twimr_pkg::OFS_LIST, twimr_pkg::OFS_ADDRESS};
  logic [31:0] msk[4] = '{32'h1fff, 32'h0, 32'h3, 32'h7f};
  wire         scl = ~scl_oe;
  wire         sda = ~sda_oe & ~sda_pull;
  always #12.5 pclk = ~pclk;
  twimr_top twimr_top_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .ram_rd_req(ram_rd_req), .ram_rd_addr(ram_rd_addr), .ram_rd_data(ram_rd_data),
    .ram_rd_valid(ram_rd_valid), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe)
  );
  twimr_slave_model twimr_slave_model_i (
    .scl(scl), .sda(sda), .own_addr(slv), .nack_at(nack_at),
    .sda_pull(sda_pull), .got_tog(got_tog), .got_byte(got_byte)
  );
  always @(got_tog) got_q.push_back(got_byte);
  // ram answers a cycle after each request
  always @(posedge pclk) begin
    ram_rd_valid <= ram_rd_req & ~ram_rd_valid;
    if (ram_rd_req && !ram_rd_valid) begin
      rb = 8'($urandom);
      ram_rd_data <= rb;
      exp_q.push_back(rb);
      adr_q.push_back(int'(ram_rd_addr));
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("mismatches %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [11:0] cmd, input int lim, input int nk, input int lst);
    int n;
    apb(1'b1, twimr_pkg::OFS_IRQ_CLR, 32'h7);
    exp_q.delete();
    got_q.delete();
    adr_q.delete();
    if (lst == 0) base = 0;
    nack_at <= 8'(nk);
    apb(1'b1, cmd, 32'h1);
    rv = 32'h0;
    while (rv[0] !== 1'b1) begin
      repeat (200) @(posedge pclk);
      apb(1'b0, twimr_pkg::OFS_EVT_STATUS, 32'h0);
    end
    repeat (300) @(posedge pclk);
    n = (nk != 0 && nk <= lim) ? nk : lim;
    chk(got_q.size(), n + 1);
    chk({24'h0, got_q[0]}, {24'h0, slv, cmd == twimr_pkg::OFS_TASK_RX});
    for (int i = 0; i < n; i++) begin
      chk({24'h0, got_q[i + 1]}, {24'h0, exp_q[i]});
      chk(adr_q[i], base + i);
    end
    if (cmd == twimr_pkg::OFS_TASK_TX) begin
      apb(1'b0, twimr_pkg::OFS_BYTES_MOVED_COUNT, 32'h0);
      chk(rv, n);
      apb(1'b0, twimr_pkg::OFS_BYTES_MOVED_COUNT, 32'h0);
      chk(rv, n);
    end
    if (lst == 1) base += lim;
  endtask
  initial begin
    void'($urandom(31));
    slv = 7'($urandom);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rv, 32'h0);
      apb(1'b1, ofs[i], 32'hffffffff);
      apb(1'b0, ofs[i], 32'h0);
      chk(rv, msk[i]);
    end
    apb(1'b0, 12'hffc, 32'h0);
    chk({rv[30:0], se}, 32'h1);
    apb(1'b1, twimr_pkg::OFS_ADDRESS, {25'h0, slv});
    apb(1'b1, twimr_pkg::OFS_LIST, 32'h1);
    apb(1'b1, twimr_pkg::OFS_BUFFER_BYTE_LIMIT, 32'h2);
    run(twimr_pkg::OFS_TASK_TX, 2, 0, 1);
    chk(irq, 1'b0);
    apb(1'b1, twimr_pkg::OFS_IRQ_EN, 32'h2);
    apb(1'b1, twimr_pkg::OFS_BUFFER_BYTE_LIMIT, 32'h3);
    run(twimr_pkg::OFS_TASK_TX, 3, 2, 1);
    chk(irq, 1'b1);
    apb(1'b0, twimr_pkg::OFS_ERR_SRC, 32'h0);
    chk(rv, 32'h4);
    apb(1'b1, twimr_pkg::OFS_IRQ_CLR, 32'h7);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b0, twimr_pkg::OFS_ERR_SRC, 32'h0);
    chk(rv, 32'h4);
    apb(1'b1, twimr_pkg::OFS_ERR_SRC, 32'h4);
    apb(1'b0, twimr_pkg::OFS_ERR_SRC, 32'h0);
    chk(rv, 32'h0);
    apb(1'b1, twimr_pkg::OFS_LIST, 32'h0);
    apb(1'b1, twimr_pkg::OFS_BUFFER_BYTE_LIMIT, 32'h1);
    run(twimr_pkg::OFS_TASK_TX, 1, 0, 0);
    run(twimr_pkg::OFS_TASK_RX, 0, 0, 0);
    end_sim();
  end
endmodule
`default_nettype wire
